/* verilog/eag_cfg.svh */
// constants for the effective address generator
`ifndef EAG_CFG_SVH
`define EAG_CFG_SVH
`define EAG_SIZE_BYTE_INC  32'h0000_0001
`define EAG_SIZE_WORD_INC  32'h0000_0002
`define EAG_SIZE_LONG_INC  32'h0000_0004
`define EAG_PC_EXT_OFFSET  32'h0000_0002
`define EAG_STACK_ALIAS    3'h7
`define EAG_EXT_ADDR_BITS  24
`define EAG_SUPER_BIT      13
`define EAG_REG_RESET      32'h0000_0000
`endif

/* verilog/eag_pkg.sv */
// types for the effective address generator
`default_nettype none
package eag_pkg;
	typedef enum logic [3:0] {
		EAG_DATA_DIRECT  = 4'h0,
		EAG_ADDR_DIRECT  = 4'h1,
		EAG_ADDR_IND     = 4'h2,
		EAG_POSTINC      = 4'h3,
		EAG_PREDEC       = 4'h4,
		EAG_ADDR_DISP    = 4'h5,
		EAG_ADDR_INDEX   = 4'h6,
		EAG_ABS_SHORT    = 4'h7,
		EAG_ABS_LONG     = 4'h8,
		EAG_PC_DISP      = 4'h9,
		EAG_PC_INDEX     = 4'ha,
		EAG_IMMEDIATE    = 4'hb,
		EAG_BRANCH_SHORT = 4'hc,
		EAG_BRANCH_LONG  = 4'hd
	} eag_mode_type;
	typedef enum logic [1:0] {
		EAG_SZ_BYTE = 2'h0,
		EAG_SZ_WORD = 2'h1,
		EAG_SZ_LONG = 2'h2
	} eag_size_type;
	typedef enum logic [1:0] {
		EAG_IDLE = 2'h1,
		EAG_DONE = 2'h2
	} eag_state_type;
endpackage
`default_nettype wire

/* verilog/eag_effective_address_generator.sv */
// effective address generator with its own general register bank
`timescale 1ns/1ps
`default_nettype none
`include "eag_cfg.svh"
module eag_effective_address_generator (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic [3:0]  ea_mode,
	input  wire logic [2:0]  addr_reg_n,
	input  wire logic [1:0]  op_size,
	input  wire logic [15:0] status_reg,
	input  wire logic [15:0] ext_word_hi,
	input  wire logic [15:0] ext_word_lo,
	input  wire logic [7:0]  opcode_disp,
	input  wire logic [3:0]  index_reg_sel,
	input  wire logic        index_long,
	input  wire logic [31:0] instr_addr,
	input  wire logic        wr_en,
	input  wire logic [4:0]  wr_sel,
	input  wire logic [31:0] wr_data,
	output logic             ea_valid_ff,
	output logic [31:0]      ea_addr_ff,
	output logic [23:0]      ext_addr_ff,
	output logic [31:0]      operand_ff,
	output logic             operand_is_reg_ff,
	output logic             ea_odd_fault_ff,
	output logic             stack_alias_reg_ff
);
	// register bank: 0..7 data, 8..14 address 0..6, 15 user, 16 supervisor
	logic [31:0]              regs_ff [0:16];
	eag_pkg::eag_state_type   state_ff;
	eag_pkg::eag_mode_type    mode_q;
	logic [4:0]               base_sel;
	logic [4:0]               idx_sel;
	logic [31:0]              base_val;
	logic [31:0]              idx_val;
	logic [31:0]              size_inc;
	logic [31:0]              nxt_ea;
	logic [31:0]              nxt_operand;
	logic                     nxt_is_reg;
	logic                     upd_reg;
	logic [31:0]              upd_val;
	logic                     is_byte;
	logic [31:0]              data_val;

	function automatic logic [31:0] sx16(input logic [15:0] v);
		sx16 = {{16{v[15]}}, v};
	endfunction

	function automatic logic [31:0] sx8(input logic [7:0] v);
		sx8 = {{24{v[7]}}, v};
	endfunction

	// maps an address register number onto the bank
	function automatic logic [4:0] areg_idx(input logic [2:0] n,
		input logic sup_mode);
		if (n == `EAG_STACK_ALIAS) begin
			areg_idx = sup_mode ? 5'h10 : 5'h0f;
		end else begin
			areg_idx = {2'h1, n};
		end
	endfunction

	assign mode_q   = eag_pkg::eag_mode_type'(ea_mode);
	assign is_byte  = (op_size == 2'(eag_pkg::EAG_SZ_BYTE));
	assign base_sel = areg_idx(addr_reg_n, status_reg[`EAG_SUPER_BIT]);
	assign idx_sel  = index_reg_sel[3]
		? areg_idx(index_reg_sel[2:0], status_reg[`EAG_SUPER_BIT])
		: {2'h0, index_reg_sel[2:0]};
	assign base_val = regs_ff[base_sel];
	assign data_val = regs_ff[{2'h0, addr_reg_n}];
	assign idx_val  = index_long ? regs_ff[idx_sel]
		: sx16(regs_ff[idx_sel][15:0]);

	always_comb begin
		unique case (op_size)
			2'(eag_pkg::EAG_SZ_BYTE): size_inc = `EAG_SIZE_BYTE_INC;
			2'(eag_pkg::EAG_SZ_WORD): size_inc = `EAG_SIZE_WORD_INC;
			default:                  size_inc = `EAG_SIZE_LONG_INC;
		endcase
	end

	always_comb begin
		nxt_ea      = 32'h0000_0000;
		nxt_operand = 32'h0000_0000;
		nxt_is_reg  = 1'b0;
		upd_reg     = 1'b0;
		upd_val     = base_val;
		case (mode_q)
			eag_pkg::EAG_DATA_DIRECT: begin
				nxt_operand = data_val;
				nxt_is_reg  = 1'b1;
			end
			eag_pkg::EAG_ADDR_DIRECT: begin
				nxt_operand = base_val;
				nxt_is_reg  = 1'b1;
			end
			eag_pkg::EAG_ADDR_IND: nxt_ea = base_val;
			eag_pkg::EAG_POSTINC: begin
				nxt_ea  = base_val;
				upd_reg = 1'b1;
				upd_val = base_val + size_inc;
			end
			eag_pkg::EAG_PREDEC: begin
				nxt_ea  = base_val - size_inc;
				upd_reg = 1'b1;
				upd_val = base_val - size_inc;
			end
			eag_pkg::EAG_ADDR_DISP: nxt_ea = base_val + sx16(ext_word_lo);
			eag_pkg::EAG_ADDR_INDEX:
				nxt_ea = base_val + sx8(opcode_disp) + idx_val;
			eag_pkg::EAG_ABS_SHORT: nxt_ea = sx16(ext_word_lo);
			eag_pkg::EAG_ABS_LONG: nxt_ea = {ext_word_hi, ext_word_lo};
			eag_pkg::EAG_PC_DISP, eag_pkg::EAG_BRANCH_LONG:
				nxt_ea = instr_addr + `EAG_PC_EXT_OFFSET
					+ sx16(ext_word_lo);
			eag_pkg::EAG_PC_INDEX:
				nxt_ea = instr_addr + `EAG_PC_EXT_OFFSET
					+ sx8(opcode_disp) + idx_val;
			eag_pkg::EAG_BRANCH_SHORT:
				nxt_ea = instr_addr + `EAG_PC_EXT_OFFSET
					+ sx8(opcode_disp);
			eag_pkg::EAG_IMMEDIATE: begin
				nxt_operand = {ext_word_hi, ext_word_lo};
				nxt_is_reg  = 1'b1;
			end
			default: nxt_ea = 32'h0000_0000;
		endcase
	end

	// register bank; address update beats a same-cycle load
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 17; i++) begin
				regs_ff[i] <= `EAG_REG_RESET;
			end
		end else begin
			if (wr_en && wr_sel <= 5'h10) begin
				regs_ff[wr_sel] <= wr_data;
			end
			if (start && upd_reg) begin
				regs_ff[base_sel] <= upd_val;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= eag_pkg::EAG_IDLE;
		end else begin
			unique case (state_ff)
				eag_pkg::EAG_IDLE:
					state_ff <= start ? eag_pkg::EAG_DONE
						: eag_pkg::EAG_IDLE;
				eag_pkg::EAG_DONE:
					state_ff <= start ? eag_pkg::EAG_DONE
						: eag_pkg::EAG_IDLE;
				default: state_ff <= eag_pkg::EAG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ea_valid_ff        <= 1'b0;
			ea_addr_ff         <= 32'h0000_0000;
			ext_addr_ff        <= 24'h00_0000;
			operand_ff         <= 32'h0000_0000;
			operand_is_reg_ff  <= 1'b0;
			ea_odd_fault_ff    <= 1'b0;
			stack_alias_reg_ff <= 1'b0;
		end else begin
			ea_valid_ff <= start;
			if (start) begin
				ea_addr_ff <= nxt_ea;
				// low 24 bits to the bus
				ext_addr_ff <= nxt_ea[`EAG_EXT_ADDR_BITS-1:0];
				operand_ff  <= nxt_operand;
				operand_is_reg_ff <= nxt_is_reg;
				// odd word or long is a fault, as is any odd pc displacement or branch address, byte size too
				ea_odd_fault_ff <= !nxt_is_reg && nxt_ea[0]
					&& (!is_byte || mode_q == eag_pkg::EAG_PC_DISP
					|| mode_q == eag_pkg::EAG_BRANCH_SHORT
					|| mode_q == eag_pkg::EAG_BRANCH_LONG);
				stack_alias_reg_ff <= base_sel == 5'h10;
			end
		end
	end

	// step requests, no bank load alongside
	sequence s_postinc_req;
		start && mode_q == eag_pkg::EAG_POSTINC && !wr_en;
	endsequence
	sequence s_predec_req;
		start && mode_q == eag_pkg::EAG_PREDEC && !wr_en;
	endsequence

	AST_DATA_DIRECT: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start && mode_q == eag_pkg::EAG_DATA_DIRECT |=>
		operand_ff == $past(data_val) && operand_is_reg_ff)
		else $error("data register operand wrong");
	AST_ALIAS: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start |=> stack_alias_reg_ff ==
		$past(addr_reg_n == 3'h7 && status_reg[13]))
		else $error("stack pointer choice wrong");
	AST_PREDEC: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		s_predec_req |=>
		ea_addr_ff == $past(base_val) - $past(size_inc)
		&& regs_ff[$past(base_sel)] == ea_addr_ff)
		else $error("predecrement wrong");
	AST_POSTINC: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		s_postinc_req |=>
		regs_ff[$past(base_sel)] == $past(base_val) + $past(size_inc)
		&& ea_addr_ff == $past(base_val))
		else $error("postincrement wrong");
	AST_DISP_SUM: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start && mode_q == eag_pkg::EAG_ADDR_DISP |=>
		ea_addr_ff == $past(base_val) + sx16($past(ext_word_lo)))
		else $error("displacement address wrong");
	AST_INDEX_SUM: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start && mode_q == eag_pkg::EAG_ADDR_INDEX |=> ea_addr_ff ==
		$past(base_val) + sx8($past(opcode_disp)) + $past(idx_val))
		else $error("indexed address wrong");
	AST_IDX_WORD: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!index_long |-> idx_val[31:16] == {16{idx_val[15]}})
		else $error("word index not sign-extended");
	AST_ABS_SHORT: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start && mode_q == eag_pkg::EAG_ABS_SHORT |=>
		ea_addr_ff == sx16($past(ext_word_lo)))
		else $error("short absolute not sign-extended");
	AST_ABS_LONG: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start && mode_q == eag_pkg::EAG_ABS_LONG |=>
		ea_addr_ff == {$past(ext_word_hi), $past(ext_word_lo)})
		else $error("long absolute modified");
	AST_PC_DISP: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start && mode_q == eag_pkg::EAG_PC_DISP |=> ea_addr_ff ==
		$past(instr_addr) + 32'h2 + sx16($past(ext_word_lo)))
		else $error("pc displacement address wrong");
	AST_BR_SHORT: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start && mode_q == eag_pkg::EAG_BRANCH_SHORT |=> ea_addr_ff ==
		$past(instr_addr) + 32'h2 + sx8($past(opcode_disp)))
		else $error("short branch target wrong");
	AST_PC_INDEX: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start && mode_q == eag_pkg::EAG_PC_INDEX |=> ea_addr_ff ==
		$past(instr_addr) + 32'h2 + sx8($past(opcode_disp))
		+ $past(idx_val))
		else $error("pc indexed address wrong");
	AST_ODD_FAULT: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		start && !is_byte && !nxt_is_reg |=>
		ea_odd_fault_ff == ea_addr_ff[0])
		else $error("odd address fault wrong");
	AST_EXT_BUS: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		ea_valid_ff |-> ext_addr_ff == ea_addr_ff[23:0])
		else $error("bus address mismatch");
	AST_VALID_STATE: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		ea_valid_ff == (state_ff == eag_pkg::EAG_DONE))
		else $error("valid pulse and state disagree");
endmodule // eag_effective_address_generator
`default_nettype wire

/* tb/eag_regfile_model.sv */
// register bank loader standing in for the core's register file
`timescale 1ns/1ps
`default_nettype none
module eag_regfile_model (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        go,
	output logic             wr_en,
	output logic [4:0]       wr_sel,
	output logic [31:0]      wr_data,
	output logic             done
);
	logic [4:0] cnt_ff;
	// one register a cycle, slots 0 to 16
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= 5'h00;
			done   <= 1'b0;
		end else if (go && !done) begin
			cnt_ff <= cnt_ff + 5'h01;
			done   <= (cnt_ff == 5'h10);
		end
	end
	assign wr_en  = go && !done;
	assign wr_sel = cnt_ff;
	// idle data inverted so a stale load never looks right
	assign wr_data = wr_en ? 32'h0001_8000 + {23'h0, cnt_ff, 4'h0}
		: ~32'h0001_8000;
endmodule // eag_regfile_model
`default_nettype wire

/* tb/effective_address_generator_bench.sv */
// self-checking bench for the effective address generator
`timescale 1ns/1ps
`default_nettype none
module effective_address_generator_bench;
	logic clk_sys = 1'b0, reset_n = 1'b0, start = 1'b0, index_long = 1'b0;
	logic go = 1'b0, wr_en, done, ea_valid_ff, operand_is_reg_ff;
	logic ea_odd_fault_ff, stack_alias_reg_ff;
	logic [3:0]  ea_mode = 4'h0, index_reg_sel = 4'h0;
	logic [2:0]  addr_reg_n = 3'h0;
	logic [1:0]  op_size = 2'h0;
	logic [15:0] status_reg = 16'h0, ext_word_hi = 16'h0, ext_word_lo = 16'h0;
	logic [7:0]  opcode_disp = 8'h0;
	logic [31:0] instr_addr = 32'h0, wr_data, ea_addr_ff, operand_ff;
	logic [4:0]  wr_sel;
	logic [23:0] ext_addr_ff;
	int n_mismatch = 0, checks_done = 0;
	eag_regfile_model i_eag_regfile_model (.clk_sys(clk_sys),
		.reset_n(reset_n), .go(go), .wr_en(wr_en), .wr_sel(wr_sel),
		.wr_data(wr_data), .done(done));
	eag_effective_address_generator i_eag_effective_address_generator (
		.clk_sys(clk_sys), .reset_n(reset_n), .start(start),
		.ea_mode(ea_mode), .addr_reg_n(addr_reg_n), .op_size(op_size),
		.status_reg(status_reg), .ext_word_hi(ext_word_hi),
		.ext_word_lo(ext_word_lo), .opcode_disp(opcode_disp),
		.index_reg_sel(index_reg_sel), .index_long(index_long),
		.instr_addr(instr_addr), .wr_en(wr_en), .wr_sel(wr_sel),
		.wr_data(wr_data), .ea_valid_ff(ea_valid_ff),
		.ea_addr_ff(ea_addr_ff), .ext_addr_ff(ext_addr_ff),
		.operand_ff(operand_ff), .operand_is_reg_ff(operand_is_reg_ff),
		.ea_odd_fault_ff(ea_odd_fault_ff),
		.stack_alias_reg_ff(stack_alias_reg_ff));
	always #50 clk_sys = ~clk_sys;
	task automatic wrap_up();
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one request, answer looked at one cycle later
	task automatic op(input logic [3:0] m, input logic [2:0] r,
		input logic [1:0] s, input logic [15:0] hi, input logic [15:0] lo,
		input logic [7:0] d, input logic [3:0] x, input logic xl);
		@(posedge clk_sys);
		start <= 1'b1;
		ea_mode <= m;
		addr_reg_n <= r;
		op_size <= s;
		ext_word_hi <= hi;
		ext_word_lo <= lo;
		opcode_disp <= d;
		index_reg_sel <= x;
		index_long <= xl;
		@(posedge clk_sys);
		start <= 1'b0;
		#1;
		chk({31'h0, ea_valid_ff}, 32'h1);
	endtask
	task automatic t_direct();
		op(4'h0, 3'h3, 2'h2, 16'h0, 16'h0, 8'h0, 4'h0, 1'b0);
		chk(operand_ff, 32'h0001_8030);
		chk({31'h0, operand_is_reg_ff}, 32'h1);
		op(4'h1, 3'h7, 2'h2, 16'h0, 16'h0, 8'h0, 4'h0, 1'b0);
		chk({operand_ff[30:0], stack_alias_reg_ff}, 32'h0003_01e0);
		@(posedge clk_sys);
		status_reg <= 16'h2000;
		op(4'h1, 3'h7, 2'h2, 16'h0, 16'h0, 8'h0, 4'h0, 1'b0);
		chk({operand_ff[30:0], stack_alias_reg_ff}, 32'h0003_0201);
		@(posedge clk_sys);
		status_reg <= 16'h0000;
	endtask
	task automatic t_step();
		op(4'h2, 3'h4, 2'h1, 16'h0, 16'h0, 8'h0, 4'h0, 1'b0);
		chk({ea_addr_ff[30:0], operand_is_reg_ff}, 32'h0003_0180);
		op(4'h3, 3'h2, 2'h1, 16'h0, 16'h0, 8'h0, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'h0001_80a0);
		op(4'h3, 3'h2, 2'h2, 16'h0, 16'h0, 8'h0, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'h0001_80a2);
		op(4'h4, 3'h2, 2'h2, 16'h0, 16'h0, 8'h0, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'h0001_80a2);
		op(4'h4, 3'h2, 2'h0, 16'h0, 16'h0, 8'h0, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'h0001_80a1);
	endtask
	task automatic t_abs();
		op(4'h5, 3'h0, 2'h1, 16'h0, 16'hfffe, 8'h0, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'h0001_807e);
		op(4'h7, 3'h0, 2'h1, 16'h0, 16'h8000, 8'h0, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'hffff_8000);
		chk({8'h0, ext_addr_ff}, 32'h00ff_8000);
		op(4'h7, 3'h0, 2'h0, 16'h0, 16'h7fff, 8'h0, 4'h0, 1'b0);
		chk({ea_addr_ff[30:0], ea_odd_fault_ff}, 32'h0000_fffe);
		op(4'h7, 3'h0, 2'h1, 16'h0, 16'h0003, 8'h0, 4'h0, 1'b0);
		chk({31'h0, ea_odd_fault_ff}, 32'h1);
		op(4'h8, 3'h0, 2'h1, 16'h0012, 16'h3456, 8'h0, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'h0012_3456);
		chk({31'h0, operand_is_reg_ff}, 32'h0);
		op(4'hb, 3'h0, 2'h2, 16'hdead, 16'hbeef, 8'h0, 4'h0, 1'b0);
		chk(operand_ff, 32'hdead_beef);
	endtask
	task automatic t_index();
		op(4'h6, 3'h1, 2'h1, 16'h0, 16'h0, 8'hf0, 4'h4, 1'b0);
		chk(ea_addr_ff, 32'h0001_00c0);
		op(4'h6, 3'h1, 2'h1, 16'h0, 16'h0, 8'hf0, 4'h4, 1'b1);
		chk(ea_addr_ff, 32'h0003_00c0);
	endtask
	task automatic t_pc();
		@(posedge clk_sys);
		instr_addr <= 32'h0000_1050;
		op(4'h9, 3'h0, 2'h1, 16'h0, 16'hf8ae, 8'h0, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'h0000_0900);
		op(4'ha, 3'h0, 2'h1, 16'h0, 16'h0, 8'hfe, 4'h9, 1'b0);
		chk(ea_addr_ff, 32'hffff_90e0);
		op(4'hc, 3'h0, 2'h1, 16'h0, 16'h0, 8'h0e, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'h0000_1060);
		op(4'hd, 3'h0, 2'h1, 16'h0, 16'hffae, 8'h0, 4'h0, 1'b0);
		chk(ea_addr_ff, 32'h0000_1000);
		op(4'hc, 3'h0, 2'h0, 16'h0, 16'h0, 8'h01, 4'h0, 1'b0);
		chk({31'h0, ea_odd_fault_ff}, 32'h1);
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b1;
		for (int i = 0; i < 40 && !done; i++)
			@(posedge clk_sys);
		t_direct();
		t_step();
		t_abs();
		t_index();
		t_pc();
		wrap_up();
	end
	// a hang is cut short well beyond the sixty-odd cycles of the run
	initial begin
		repeat (2000) @(posedge clk_sys);
		n_mismatch++;
		wrap_up();
	end
endmodule // effective_address_generator_bench
`default_nettype wire
